// ### hdl/bit_sync.sv
// Two-flop synchroniser for a single level.
// Assumes the input is asynchronous to clk; only the second flop is read.
`timescale 1ns/100ps
module bit_sync #(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in and out
    input wire logic d,
    output logic q
);
    logic meta_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule : bit_sync

// ### hdl/serial_host_port.sv
// Data and address pin logic of a dual-mode SPI / I2C serial host port.
// Assumes mode inputs are static during transfers and SCL/SDA are pulled up.
`timescale 1ns/100ps

module serial_host_port (
    // System clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Serial link clock
    input wire logic linkClk,
    // Mode selection
    input wire logic modeI2c,
    input wire logic modeMaster,
    input wire logic [shp_pkg::ADDR_HI_W-1:0] ownAddrHi,
    // SPI pins
    input wire logic ssN,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe,
    // I2C pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic slave_addr_bit0_pin,
    // Received data stream
    output logic rxValid,
    input wire logic rxReady,
    output logic [shp_pkg::BYTE_W-1:0] rxData,
    // Status
    output logic overrun,
    output logic busIdle
);
    import shp_pkg::*;

    // ****************************************
    // Reset release
    // ****************************************
    logic rstMeta_ff;
    logic rstSync_n;
    logic linkRstMeta_ff;
    logic linkRst_n;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstMeta_ff <= 1'b0;
            rstSync_n <= 1'b0;
        end
        else
        begin
            rstMeta_ff <= 1'b1;
            rstSync_n <= rstMeta_ff;
        end
    end

    always_ff @(posedge linkClk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            linkRstMeta_ff <= 1'b0;
            linkRst_n <= 1'b0;
        end
        else
        begin
            linkRstMeta_ff <= 1'b1;
            linkRst_n <= linkRstMeta_ff;
        end
    end

    // ****************************************
    // SPI shifter on the link clock
    // ****************************************
    logic spiShift;
    logic spiBit;
    logic [2:0] spiCnt_ff;
    logic [7:0] spiRx_ff;
    logic [7:0] spiTx_ff;
    logic [7:0] linkByte_ff;
    logic linkTgl_ff;
    logic outBit_ff;

    assign spiShift = !modeI2c && (modeMaster || !ssN);
    assign spiBit = modeMaster ? misoIn : mosiIn;

    always_ff @(posedge linkClk or negedge linkRst_n)
    begin
        if (!linkRst_n)
        begin
            spiCnt_ff <= BIT_CNT_RST;
            spiRx_ff <= BYTE_RST;
            spiTx_ff <= TX_RST;
            linkByte_ff <= BYTE_RST;
            linkTgl_ff <= 1'b0;
        end
        else if (spiShift)
        begin
            spiCnt_ff <= spiCnt_ff + 1'b1;
            spiRx_ff <= {spiRx_ff[6:0], spiBit};
            spiTx_ff <= {spiTx_ff[6:0], 1'b1};
            if (spiCnt_ff == BIT_CNT_LAST)
            begin
                // Echo the last byte back; held 8 link clocks for the crossing
                linkByte_ff <= {spiRx_ff[6:0], spiBit};
                spiTx_ff <= {spiRx_ff[6:0], spiBit};
                linkTgl_ff <= ~linkTgl_ff;
            end
        end
        else
            spiCnt_ff <= BIT_CNT_RST;
    end

    // Launch on the opposite edge so data is stable at the sampling edge
    always_ff @(negedge linkClk or negedge linkRst_n)
    begin
        if (!linkRst_n)
            outBit_ff <= 1'b1;
        else if (spiShift)
            outBit_ff <= spiTx_ff[7];
    end

    assign mosiOut = outBit_ff;
    assign mosiOe = rstSync_n && !modeI2c && modeMaster;
    assign misoOut = outBit_ff;
    assign misoOe = rstSync_n && !modeI2c && !modeMaster && !ssN;

    // ****************************************
    // Byte crossing into the system clock
    // ****************************************
    logic tglS;
    logic tglD_ff;
    logic spiNew;

    bit_sync #(.INIT(1'b0)) u_tglSync (
        .clk(clk),
        .rst_n(rstSync_n),
        .d(linkTgl_ff),
        .q(tglS)
    );

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            tglD_ff <= 1'b0;
        else
            tglD_ff <= tglS;
    end

    assign spiNew = (tglS != tglD_ff) && !modeI2c;

    // ****************************************
    // I2C pin sampling and bus events
    // ****************************************
    logic sclS;
    logic sdaS;
    logic addrPinS;
    logic sclD_ff;
    logic sdaD_ff;
    logic sclRise;
    logic sclFall;
    logic startEv;
    logic stopEv;
    logic i2cSlave;

    bit_sync #(.INIT(1'b1)) u_sclSync (
        .clk(clk),
        .rst_n(rstSync_n),
        .d(sclIn),
        .q(sclS)
    );

    bit_sync #(.INIT(1'b1)) u_sdaSync (
        .clk(clk),
        .rst_n(rstSync_n),
        .d(sdaIn),
        .q(sdaS)
    );

    bit_sync #(.INIT(1'b0)) u_addrPinSync (
        .clk(clk),
        .rst_n(rstSync_n),
        .d(slave_addr_bit0_pin),
        .q(addrPinS)
    );

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            sclD_ff <= 1'b1;
            sdaD_ff <= 1'b1;
        end
        else
        begin
            sclD_ff <= sclS;
            sdaD_ff <= sdaS;
        end
    end

    assign sclRise = sclS && !sclD_ff;
    assign sclFall = !sclS && sclD_ff;
    assign startEv = sclS && sclD_ff && sdaD_ff && !sdaS;
    assign stopEv = sclS && sclD_ff && !sdaD_ff && sdaS;
    assign i2cSlave = modeI2c && !modeMaster;

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            busIdle <= 1'b1;
        else if (!modeI2c || stopEv)
            busIdle <= 1'b1;
        else if (startEv)
            busIdle <= 1'b0;
    end

    // ****************************************
    // I2C slave receiver
    // ****************************************
    i2c_state_type state_ff;
    i2c_state_type nxt_state;
    logic [2:0] i2cCnt_ff;
    logic [7:0] i2cRx_ff;
    logic byteDone_ff;
    logic addrPinLat_ff;
    logic addrMatch;
    logic i2cPush;
    logic fifoInReady;

    // Address bit zero sits one above the read/write bit
    assign addrMatch = (i2cRx_ff[7:2] == ownAddrHi) && (i2cRx_ff[1] == addrPinLat_ff)
        && !i2cRx_ff[0];

    // Pin level caught at the start condition, only in the slave role
    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            addrPinLat_ff <= 1'b0;
        else if (i2cSlave && startEv)
            addrPinLat_ff <= addrPinS;
    end

    always_comb
    begin
        nxt_state = state_ff;
        if (!i2cSlave)
            nxt_state = I2C_IDLE;
        else if (startEv)
            nxt_state = I2C_ADDR;
        else if (stopEv)
            nxt_state = I2C_IDLE;
        else if (sclFall)
        begin
            case (state_ff)
                I2C_ADDR:
                    if (byteDone_ff)
                        nxt_state = addrMatch ? I2C_ADDR_ACK : I2C_SKIP;
                I2C_DATA:
                    // A full buffer leaves the acknowledge unsent to hold off the host
                    if (byteDone_ff)
                        nxt_state = fifoInReady ? I2C_DATA_ACK : I2C_SKIP;
                I2C_ADDR_ACK,
                I2C_DATA_ACK:
                    nxt_state = I2C_DATA;
                I2C_IDLE,
                I2C_SKIP:
                    nxt_state = state_ff;
                default:
                    nxt_state = I2C_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            state_ff <= I2C_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            i2cCnt_ff <= BIT_CNT_RST;
            i2cRx_ff <= BYTE_RST;
            byteDone_ff <= 1'b0;
        end
        else if (startEv || (sclFall && byteDone_ff))
        begin
            i2cCnt_ff <= BIT_CNT_RST;
            byteDone_ff <= 1'b0;
        end
        else if (sclRise && (state_ff == I2C_ADDR || state_ff == I2C_DATA))
        begin
            i2cRx_ff <= {i2cRx_ff[6:0], sdaS};
            i2cCnt_ff <= i2cCnt_ff + 1'b1;
            byteDone_ff <= (i2cCnt_ff == BIT_CNT_LAST);
        end
    end

    assign i2cPush = i2cSlave && !startEv && !stopEv && sclFall
        && state_ff == I2C_DATA && byteDone_ff && fifoInReady;

    // Pulled low only for acknowledge bits, entered and left on SCL low
    assign sdaOut = 1'b0;
    assign sdaOe = rstSync_n && (state_ff == I2C_ADDR_ACK
        || state_ff == I2C_DATA_ACK);

    // ****************************************
    // Receive buffer
    // ****************************************
    logic fifoInValid;
    logic [7:0] fifoInData;

    assign fifoInValid = spiNew || i2cPush;
    assign fifoInData = modeI2c ? i2cRx_ff : linkByte_ff;

    stream_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rxFifo (
        .clk(clk),
        .rst_n(rstSync_n),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(rxValid),
        .outReady(rxReady),
        .outData(rxData)
    );

    // SPI cannot be stalled, so a byte arriving at a full buffer is lost
    always_ff @(posedge clk or negedge rstSync_n)
    begin
        if (!rstSync_n)
            overrun <= 1'b0;
        else if (spiNew && !fifoInReady)
            overrun <= 1'b1;
        else if (rxValid && rxReady)
            overrun <= 1'b0;
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_miso_float: assert property (@(posedge clk) disable iff (!rstSync_n)
        ssN |-> !misoOe) else $error("MISO driven while slave select high");
    a_data_dirs: assert property (@(posedge clk) disable iff (!rstSync_n)
        !(misoOe && mosiOe) && !(modeI2c && (misoOe || mosiOe)))
        else $error("SPI data lines driven in the wrong role");
    a_spi_hold: assert property (@(posedge linkClk) disable iff (!linkRst_n)
        (ssN && !modeMaster) |=> spiCnt_ff == BIT_CNT_RST)
        else $error("SPI shifted without slave select");
    a_sda_reset: assert property (@(posedge clk) disable iff (1'b0)
        !rstSync_n |-> !sdaOe) else $error("SDA driven during reset");
    a_sda_scl_low: assert property (@(posedge clk) disable iff (!rstSync_n)
        $changed(sdaOe) |-> !sclS) else $error("SDA changed while SCL high");
    a_idle_released: assert property (@(posedge clk) disable iff (!rstSync_n)
        busIdle |-> !sdaOe) else $error("SDA driven on idle bus");
    a_start_addr: assert property (@(posedge clk) disable iff (!rstSync_n)
        (i2cSlave && startEv) |=> state_ff == I2C_ADDR ##0 !busIdle)
        else $error("Start condition not taken");
    a_stop_idle: assert property (@(posedge clk) disable iff (!rstSync_n)
        (i2cSlave && stopEv && !startEv) |=> state_ff == I2C_IDLE && busIdle)
        else $error("Stop condition not taken");
    a_addr_match: assert property (@(posedge clk) disable iff (!rstSync_n)
        $rose(state_ff == I2C_ADDR_ACK) |-> $past(addrMatch) && $past(byteDone_ff))
        else $error("Acknowledge without address match");
    a_master_quiet: assert property (@(posedge clk) disable iff (!rstSync_n)
        $past(modeMaster) |-> state_ff == I2C_IDLE && !sdaOe)
        else $error("I2C master reacted as slave");
    a_addr_pin_latch: assert property (@(posedge clk) disable iff (!rstSync_n)
        (i2cSlave && startEv) |=> addrPinLat_ff == $past(addrPinS))
        else $error("Address pin not sampled at start");
    a_push_ack: assert property (@(posedge clk) disable iff (!rstSync_n)
        i2cPush |=> state_ff == I2C_DATA_ACK ##0 sdaOe)
        else $error("Stored byte not acknowledged");

    c_spi_byte: cover property (@(posedge clk) disable iff (!rstSync_n) spiNew);
    c_i2c_ack: cover property (@(posedge clk) disable iff (!rstSync_n)
        state_ff == I2C_DATA_ACK);
    c_overrun: cover property (@(posedge clk) disable iff (!rstSync_n) $rose(overrun));
    c_nack: cover property (@(posedge clk) disable iff (!rstSync_n)
        $rose(state_ff == I2C_SKIP));
endmodule : serial_host_port

// ### hdl/shp_pkg.sv
// Shared constants and types for the serial host port data pins.
// Assumes a 20 MHz system clock and an unrelated serial link clock.
package shp_pkg;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int ADDR_HI_W = 6;
    localparam logic [2:0] BIT_CNT_RST = 3'h0;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] TX_RST = 8'hff;
    localparam logic [4:0] FIFO_CNT_RST = 5'h00;
    localparam logic [3:0] FIFO_PTR_RST = 4'h0;

    typedef enum logic [5:0] {
        I2C_IDLE = 6'h01,
        I2C_ADDR = 6'h02,
        I2C_ADDR_ACK = 6'h04,
        I2C_DATA = 6'h08,
        I2C_DATA_ACK = 6'h10,
        I2C_SKIP = 6'h20
    } i2c_state_type;
endpackage : shp_pkg

// ### hdl/stream_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/100ps
module stream_fifo
    import shp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign inReady = (count_ff != DEPTH[AW:0]);
    assign outValid = (count_ff != '0);
    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign outData = mem_ff[rdPtr_ff];

    // Storage carries no reset; empty flag guards stale words
    always_ff @(posedge clk)
    begin
        if (push)
            mem_ff[wrPtr_ff] <= inData;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (push)
                wrPtr_ff <= wrPtr_ff + 1'b1;
            if (pop)
                rdPtr_ff <= rdPtr_ff + 1'b1;
            if (push && !pop)
                count_ff <= count_ff + 1'b1;
            else if (pop && !push)
                count_ff <= count_ff - 1'b1;
        end
    end
endmodule : stream_fifo

// ### test/host_model.sv
// Far-side model: SPI peer (master or slave) and I2C master on the pins.
// Assumes the bench resolves the pulled-up SDA and SCL wires from all drivers.
`timescale 1ns/100ps
module host_model (
    // SPI side
    output logic linkClk,
    output logic ssN,
    output logic mosiIn,
    output logic misoIn,
    input wire logic misoOe,
    input wire logic mosiOe,
    input wire logic mosiOut,
    input wire logic misoOut,
    // I2C side
    output logic sclLow,
    output logic sdaLow,
    input wire logic sdaLine
);
    initial
    begin
        linkClk = 1'b0;
        ssN = 1'b1;
        mosiIn = 1'b0;
        misoIn = 1'b1;
        sclLow = 1'b0;
        sdaLow = 1'b0;
    end

    // ********************************
    // SPI frame, one byte MSB first
    // ********************************
    // The unused data line carries the inverse, so a wrong line choice shows
    task automatic spi(input logic master, input logic sel, input logic [7:0] b,
                       output logic oe, output logic [7:0] got);
        ssN = ~sel | master;
        #30;
        for (int i = 7; i >= 0; i--)
        begin
            mosiIn = master ? ~b[i] : b[i];
            misoIn = master ? b[i] : ~b[i];
            #40;
            linkClk = 1'b1;
            got[i] = master ? mosiOut : misoOut;
            if (i == 3)
                oe = master ? mosiOe : misoOe;
            #40;
            linkClk = 1'b0;
        end
        #30;
        ssN = 1'b1;
        mosiIn = ~mosiIn;
        misoIn = ~misoIn;
    endtask : spi

    // ********************************
    // I2C master, data moves only with SCL low
    // ********************************
    task automatic i2c_start();
        // Release SDA under SCL low first, so a repeated start is seen too
        sdaLow = 1'b0;
        #250;
        sclLow = 1'b0;
        #500;
        sdaLow = 1'b1;
        #500;
        sclLow = 1'b1;
        #250;
    endtask : i2c_start

    task automatic i2c_stop();
        sdaLow = 1'b1;
        #250;
        sclLow = 1'b0;
        #500;
        sdaLow = 1'b0;
        #500;
    endtask : i2c_stop

    task automatic byte_out(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sdaLow = ~b[i];
            #250;
            sclLow = 1'b0;
            #500;
            sclLow = 1'b1;
            #250;
        end
        sdaLow = 1'b0;
        #250;
        sclLow = 1'b0;
        #250;
        ack = ~sdaLine;
        #250;
        sclLow = 1'b1;
        #250;
    endtask : byte_out
endmodule : host_model

// ### test/serial_host_port_tb.sv
// Self-checking bench for the serial host port data pins.
// Assumes host_model plays the far side; SDA and SCL are resolved here.
`timescale 1ns/100ps
module serial_host_port_tb;
    import shp_pkg::*;
    logic clk, arst_n, linkClk, modeI2c, modeMaster, ssN, mosiIn, mosiOut, mosiOe;
    logic misoIn, misoOut, misoOe, sdaOut, sdaOe, addrPin, rxValid, rxReady;
    logic overrun, busIdle, sclLow, sdaLow, sdaLine, sclLine, oe, ack;
    logic [ADDR_HI_W-1:0] ownAddrHi;
    logic [BYTE_W-1:0] rxData;
    logic [BYTE_W-1:0] echo;
    int bad_count, compares, cycles;

    // Open-drain wires with pull-ups
    assign sdaLine = ~((sdaOe & ~sdaOut) | sdaLow);
    assign sclLine = ~sclLow;

    serial_host_port serial_host_port_i (.clk(clk), .arst_n(arst_n), .linkClk(linkClk),
        .modeI2c(modeI2c), .modeMaster(modeMaster), .ownAddrHi(ownAddrHi), .ssN(ssN),
        .mosiIn(mosiIn), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoIn),
        .misoOut(misoOut), .misoOe(misoOe), .sclIn(sclLine), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .slave_addr_bit0_pin(addrPin),
        .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData), .overrun(overrun),
        .busIdle(busIdle));

    host_model host_model_i (.linkClk(linkClk), .ssN(ssN), .mosiIn(mosiIn),
        .misoIn(misoIn), .misoOe(misoOe), .mosiOe(mosiOe), .mosiOut(mosiOut),
        .misoOut(misoOut), .sclLow(sclLow),
        .sdaLow(sdaLow), .sdaLine(sdaLine));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ********************************
    // Helpers
    // ********************************
    task results();
        if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // Ceiling well above the roughly 1900 cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            bad_count++;
            results();
        end
    end

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task pop(input logic [7:0] exp);
        for (int n = 0; n < 200 && rxValid !== 1'b1; n++)
            tick(1);
        chk(rxValid, 1'b1);
        chk(rxData, exp);
        rxReady = 1'b1;
        tick(1);
        rxReady = 1'b0;
        tick(1);
    endtask : pop

    // ********************************
    // Scenarios
    // ********************************
    task spi_slave();
        modeI2c = 1'b0;
        modeMaster = 1'b0;
        host_model_i.spi(1'b0, 1'b0, 8'h5a, oe, echo);
        chk(oe, 1'b0);
        tick(20);
        chk(rxValid, 1'b0);
        // Seventeen frames into an undrained 16-word buffer: the last is dropped
        for (int i = 0; i < 17; i++)
        begin
            host_model_i.spi(1'b0, 1'b1, 8'h10 + 8'(i), oe, echo);
            chk(oe, 1'b1);
            chk(echo, (i == 0) ? TX_RST : 8'h0f + 8'(i));
        end
        tick(10);
        chk(overrun, 1'b1);
        for (int i = 0; i < 16; i++)
        begin
            pop(8'h10 + 8'(i));
            if (i == 0)
                chk(overrun, 1'b0);
        end
        tick(5);
        chk(rxValid, 1'b0);
    endtask : spi_slave

    task spi_master();
        modeMaster = 1'b1;
        host_model_i.spi(1'b1, 1'b1, 8'hc3, oe, echo);
        chk(oe, 1'b1);
        chk(echo, 8'h20);
        chk(misoOe, 1'b0);
        pop(8'hc3);
    endtask : spi_master

    task i2c_slave();
        modeI2c = 1'b1;
        modeMaster = 1'b0;
        ownAddrHi = 6'h2a;
        addrPin = 1'b1;
        tick(4);
        chk(busIdle, 1'b1);
        host_model_i.i2c_start();
        tick(4);
        chk(busIdle, 1'b0);
        host_model_i.byte_out(8'hab, ack);
        chk(ack, 1'b0);
        host_model_i.i2c_start();
        host_model_i.byte_out(8'haa, ack);
        chk(ack, 1'b1);
        host_model_i.byte_out(8'h3c, ack);
        chk(ack, 1'b1);
        host_model_i.i2c_stop();
        tick(4);
        chk(busIdle, 1'b1);
        pop(8'h3c);
        // Address bit zero no longer matches the pin
        addrPin = 1'b0;
        host_model_i.i2c_start();
        host_model_i.byte_out(8'haa, ack);
        chk(ack, 1'b0);
        host_model_i.byte_out(8'h3c, ack);
        chk(ack, 1'b0);
        host_model_i.i2c_start();
        host_model_i.byte_out(8'ha8, ack);
        chk(ack, 1'b1);
        host_model_i.i2c_stop();
    endtask : i2c_slave

    task i2c_master();
        tick(1);
        modeMaster = 1'b1;
        addrPin = 1'b1;
        host_model_i.i2c_start();
        host_model_i.byte_out(8'haa, ack);
        chk(ack, 1'b0);
        host_model_i.i2c_stop();
        tick(20);
        chk(rxValid, 1'b0);
    endtask : i2c_master

    initial
    begin
        arst_n = 1'b0;
        modeI2c = 1'b1;
        modeMaster = 1'b0;
        ownAddrHi = 6'h00;
        addrPin = 1'b0;
        rxReady = 1'b0;
        bad_count = 0;
        compares = 0;
        cycles = 0;
        tick(16);
        chk(sdaOe, 1'b0);
        chk(sdaLine, 1'b1);
        arst_n = 1'b1;
        tick(4);
        spi_slave();
        spi_master();
        i2c_slave();
        i2c_master();
        results();
    end
endmodule : serial_host_port_tb
